// *** fan_model.sv ***
// Cooling fan model: measures period and high time of its drive
`timescale 1ns/10ps
`default_nettype none
module fan_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic pwm_in,
   output logic [31:0] period_cycles,
   output logic [31:0] high_cycles,
   output logic [31:0] edge_cnt
);
   logic prev_ff;
   logic [31:0] cnt_ff;
   logic [31:0] hi_ff;
   // Each rising edge closes one measured period
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_ff <= 1'b0;
         cnt_ff <= 32'h0;
         hi_ff <= 32'h0;
         period_cycles <= 32'h0;
         high_cycles <= 32'h0;
         edge_cnt <= 32'h0;
      end else begin
         prev_ff <= pwm_in;
         cnt_ff <= cnt_ff + 32'h1;
         hi_ff <= hi_ff + {31'h0, pwm_in};
         if (pwm_in && !prev_ff) begin
            period_cycles <= cnt_ff;
            high_cycles <= hi_ff;
            edge_cnt <= edge_cnt + 32'h1;
            cnt_ff <= 32'h1;
            hi_ff <= 32'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** fan_pwm_defines.svh ***
// Constants for the second fan output spin-up and frequency block
// What this block does
// - The four-bit spin-up duty code in bits 3:0 picks the spin-up duty through the same sixteen-entry code map as the temperature tables.
// - A spin-up duty code of zero means no spin-up ever happens.
// - The four-bit spin-up duration code takes bit 4 as its top bit and bits 7:5 as its three low bits.
// - A step of the output duty from zero to anything non-zero starts spin-up for the programmed time.
// - With the top duration bit clear, low codes 0 to 7 mean disabled, 100 ms, 250 ms, 400 ms, 700 ms, 1 s, 2 s and 4 s.
// - With the top duration bit set, low codes 0 to 7 mean 6 s to 20 s in 2 s steps.
// - The three-bit frequency code in bits 2:0 picks 22500, 96, 84, 72, 60, 48, 36 or 12 Hz.
// - At 22.5 kHz with map select clear, steps 1 to 13 give 25% rising 6.25% per step to 100%.
// - With map select set, steps 1 to 13 follow the low-frequency map from 25% through 57.14%, 71.43%, 85.71% to 100%.
// - The map select acts on every duty source: four tables, both hot ramps, spin-up and override.
// - At any frequency other than 22.5 kHz the map select is ignored and the low-frequency map is used.
// - When several sources request duty at once the largest request is driven, except during spin-up, when the spin-up duty code is driven.
`ifndef FAN_PWM_DEFINES_SVH
`define FAN_PWM_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define SPINUP_CFG_ADDR 8'hce
`define FREQ_MAP_CFG_ADDR 8'hcf
`define SPINUP_CFG_RESET 8'h00
`define FREQ_MAP_CFG_RESET 8'h00
`define DUTY_CODE_LSB 0
`define DUTY_CODE_MSB 3
`define DUR_TOP_BIT 4
`define DUR_LOW_LSB 5
`define DUR_LOW_MSB 7
`define FREQ_CODE_LSB 0
`define FREQ_CODE_MSB 2
`define MAP_SEL_BIT 3

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 100000000
`define MS_PER_S 1000
`define CLK_PER_MS (`CLK_HZ / `MS_PER_S)
`define DUR_MS_1 100
`define DUR_MS_2 250
`define DUR_MS_3 400
`define DUR_MS_4 700
`define DUR_MS_5 1000
`define DUR_MS_6 2000
`define DUR_MS_7 4000
`define DUR_LONG_BASE_MS 6000
`define DUR_LONG_STEP_MS 2000

// ****************************************
// Output frequencies in Hz
// ****************************************
`define FREQ_HZ_0 22500
`define FREQ_HZ_1 96
`define FREQ_HZ_2 84
`define FREQ_HZ_3 72
`define FREQ_HZ_4 60
`define FREQ_HZ_5 48
`define FREQ_HZ_6 36
`define FREQ_HZ_7 12
`define HIGH_FREQ_CODE 3'h0

// ****************************************
// Duty maps: fraction num/den
// ****************************************
`define HIGH_MAP_DEN 6'd16
`define HIGH_MAP_OFFSET 6'd3
`define LOW_MAP_DEN 6'd28
`define DUTY_TOP_STEP 4'hd

`endif

// *** fan_pwm_pkg.sv ***
// Types shared by the fan output spin-up block
package fan_pwm_pkg;
   typedef enum logic [1:0] {
      SPIN_IDLE = 2'b01,
      SPIN_RUN = 2'b10
   } spin_state_t;
   typedef logic [3:0] duty_code_t;
   typedef logic [2:0] freq_code_t;
endpackage

// *** fan_pwm_spinup.sv ***
// Second fan output: configuration registers, source merge, spin-up
`include "fan_pwm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_spinup
   import fan_pwm_pkg::*;
#(
   parameter int clk_hz = `CLK_HZ,
   parameter int clk_per_ms = `CLK_PER_MS
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [3:0] table1_code,
   input wire logic [3:0] table2_code,
   input wire logic [3:0] table3_code,
   input wire logic [3:0] table4_code,
   input wire logic [3:0] regulator_hot_code,
   input wire logic [3:0] processor_hot_code,
   input wire logic override_en,
   input wire logic [3:0] override_code,
   output logic second_fan_output,
   output logic spinup_active,
   output logic [3:0] applied_duty_code
);

   // ****************************************
   // Configuration registers
   // ****************************************
   logic [7:0] spinup_cfg_ff;
   logic [3:0] freq_map_cfg_ff;
   duty_code_t spinup_duty_code;
   logic [3:0] spinup_duration_code;
   freq_code_t second_output_frequency_code;
   logic high_freq_map_select;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spinup_cfg_ff <= `SPINUP_CFG_RESET;
      end else if (reg_wr_en && reg_addr == `SPINUP_CFG_ADDR) begin
         spinup_cfg_ff <= reg_wdata;
      end
   end

   // Upper nibble is reserved and not stored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         freq_map_cfg_ff <= 4'(`FREQ_MAP_CFG_RESET);
      end else if (reg_wr_en && reg_addr == `FREQ_MAP_CFG_ADDR) begin
         freq_map_cfg_ff <= reg_wdata[3:0];
      end
   end

   assign spinup_duty_code =
      spinup_cfg_ff[`DUTY_CODE_MSB:`DUTY_CODE_LSB];
   assign spinup_duration_code = {spinup_cfg_ff[`DUR_TOP_BIT],
      spinup_cfg_ff[`DUR_LOW_MSB:`DUR_LOW_LSB]};
   assign second_output_frequency_code =
      freq_map_cfg_ff[`FREQ_CODE_MSB:`FREQ_CODE_LSB];
   assign high_freq_map_select = freq_map_cfg_ff[`MAP_SEL_BIT];

   // ****************************************
   // Register read port
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         case (reg_addr)
            `SPINUP_CFG_ADDR: begin
               reg_rdata <= spinup_cfg_ff;
            end
            `FREQ_MAP_CFG_ADDR: begin
               reg_rdata <= {4'h0, freq_map_cfg_ff};
            end
            default: begin
               reg_rdata <= 8'h00;
            end
         endcase
      end
   end

   // ****************************************
   // Largest request wins
   // ****************************************
   logic [3:0] src_code [0:6];
   logic [3:0] max_stage [0:7];
   duty_code_t requested_code;

   assign src_code[0] = table1_code;
   assign src_code[1] = table2_code;
   assign src_code[2] = table3_code;
   assign src_code[3] = table4_code;
   assign src_code[4] = regulator_hot_code;
   assign src_code[5] = processor_hot_code;
   assign src_code[6] = override_en ? override_code : 4'h0;
   assign max_stage[0] = 4'h0;

   // Codes are monotonic in duty within either map, so max code = max duty
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi = gi + 1) begin : g_max
         assign max_stage[gi + 1] = (src_code[gi] > max_stage[gi]) ?
            src_code[gi] : max_stage[gi];
      end
   endgenerate

   assign requested_code = max_stage[7];

   // ****************************************
   // Spin-up duration lookup
   // ****************************************
   function automatic logic [14:0] dur_ms(input logic [3:0] code);
      logic [14:0] ms;
      ms = 15'h0000;
      if (code[3]) begin
         ms = 15'(`DUR_LONG_BASE_MS + `DUR_LONG_STEP_MS * code[2:0]);
      end else begin
         case (code[2:0])
            3'h1: ms = 15'(`DUR_MS_1);
            3'h2: ms = 15'(`DUR_MS_2);
            3'h3: ms = 15'(`DUR_MS_3);
            3'h4: ms = 15'(`DUR_MS_4);
            3'h5: ms = 15'(`DUR_MS_5);
            3'h6: ms = 15'(`DUR_MS_6);
            3'h7: ms = 15'(`DUR_MS_7);
            default: ms = 15'h0000;
         endcase
      end
      return ms;
   endfunction

   logic [14:0] spin_ms_target;
   logic spin_enabled;

   assign spin_ms_target = dur_ms(spinup_duration_code);
   assign spin_enabled = (spinup_duty_code != 4'h0) &&
      (spin_ms_target != 15'h0000);

   // ****************************************
   // Millisecond tick
   // ****************************************
   logic [31:0] tick_cnt_ff;
   logic ms_tick;
   spin_state_t spin_state_ff;

   assign ms_tick = (tick_cnt_ff == 32'(clk_per_ms - 1));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_ff <= 32'h00000000;
      end else if (ms_tick || spin_state_ff == SPIN_IDLE) begin
         tick_cnt_ff <= 32'h00000000;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      end
   end

   // ****************************************
   // Spin-up state machine
   // ****************************************
   spin_state_t nxt_spin_state;
   logic [14:0] ms_cnt_ff;
   logic prev_req_zero_ff;
   logic zero_to_nonzero;
   logic spin_done;

   assign zero_to_nonzero = prev_req_zero_ff &&
      (requested_code != 4'h0);
   assign spin_done = ms_tick &&
      (ms_cnt_ff + 15'h0001 >= spin_ms_target);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_req_zero_ff <= 1'b1;
      end else begin
         prev_req_zero_ff <= (requested_code == 4'h0);
      end
   end

   always_comb begin
      nxt_spin_state = spin_state_ff;
      case (spin_state_ff)
         SPIN_IDLE: begin
            if (zero_to_nonzero && spin_enabled) begin
               nxt_spin_state = SPIN_RUN;
            end
         end
         SPIN_RUN: begin
            // Dropping to zero or disabling ends the cycle at once
            if (spin_done || !spin_enabled ||
                requested_code == 4'h0) begin
               nxt_spin_state = SPIN_IDLE;
            end
         end
         default: begin
            nxt_spin_state = SPIN_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spin_state_ff <= SPIN_IDLE;
      end else begin
         spin_state_ff <= nxt_spin_state;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ms_cnt_ff <= 15'h0000;
      end else if (spin_state_ff == SPIN_IDLE) begin
         ms_cnt_ff <= 15'h0000;
      end else if (ms_tick) begin
         ms_cnt_ff <= ms_cnt_ff + 15'h0001;
      end
   end

   // ****************************************
   // Duty selection and map
   // ****************************************
   duty_code_t out_code;
   logic use_high_map;
   logic [5:0] duty_num;
   logic [5:0] duty_den;

   assign out_code = (spin_state_ff == SPIN_RUN) ?
      spinup_duty_code : requested_code;
   // One map choice for every source, since all pass through out_code
   assign use_high_map = (second_output_frequency_code ==
      `HIGH_FREQ_CODE) && !high_freq_map_select;

   function automatic logic [5:0] low_num(input logic [3:0] code);
      logic [5:0] n;
      n = 6'h00;
      case (code)
         4'h0: n = 6'h00;
         4'h1: n = 6'd7;
         4'h2: n = 6'd8;
         4'h3: n = 6'd9;
         4'h4: n = 6'd10;
         4'h5: n = 6'd11;
         4'h6: n = 6'd12;
         4'h7: n = 6'd13;
         4'h8: n = 6'd14;
         4'h9: n = 6'd15;
         4'ha: n = 6'd16;
         4'hb: n = 6'd20;
         4'hc: n = 6'd24;
         default: n = `LOW_MAP_DEN;
      endcase
      return n;
   endfunction

   always_comb begin
      duty_num = 6'h00;
      duty_den = `LOW_MAP_DEN;
      if (use_high_map) begin
         duty_den = `HIGH_MAP_DEN;
         if (out_code == 4'h0) begin
            duty_num = 6'h00;
         end else if (out_code >= `DUTY_TOP_STEP) begin
            duty_num = `HIGH_MAP_DEN;
         end else begin
            duty_num = {2'b00, out_code} + `HIGH_MAP_OFFSET;
         end
      end else begin
         duty_num = low_num(out_code);
      end
   end

   // ****************************************
   // Output period
   // ****************************************
   logic [23:0] period_cycles;

   always_comb begin
      case (second_output_frequency_code)
         3'h0: period_cycles = 24'(clk_hz / `FREQ_HZ_0);
         3'h1: period_cycles = 24'(clk_hz / `FREQ_HZ_1);
         3'h2: period_cycles = 24'(clk_hz / `FREQ_HZ_2);
         3'h3: period_cycles = 24'(clk_hz / `FREQ_HZ_3);
         3'h4: period_cycles = 24'(clk_hz / `FREQ_HZ_4);
         3'h5: period_cycles = 24'(clk_hz / `FREQ_HZ_5);
         3'h6: period_cycles = 24'(clk_hz / `FREQ_HZ_6);
         3'h7: period_cycles = 24'(clk_hz / `FREQ_HZ_7);
         default: period_cycles = 24'(clk_hz / `FREQ_HZ_0);
      endcase
   end

   fan_pwm_wave u_wave (
      .clk(clk),
      .arst_n(arst_n),
      .period_cycles(period_cycles),
      .duty_num(duty_num),
      .duty_den(duty_den),
      .pwm_out(second_fan_output)
   );

   // ****************************************
   // Status outputs
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         spinup_active <= 1'b0;
         applied_duty_code <= 4'h0;
      end else begin
         spinup_active <= (nxt_spin_state == SPIN_RUN);
         // Follows the next state so it tracks spinup_active edge for edge
         applied_duty_code <= (nxt_spin_state == SPIN_RUN) ?
            spinup_duty_code : requested_code;
      end
   end

endmodule
`default_nettype wire

// *** fan_pwm_spinup_asserts.sv ***
// Checker for the second fan output spin-up block
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_spinup_asserts #(
   parameter int clk_hz = 100000000,
   parameter int clk_per_ms = 100000
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic [3:0] table1_code,
   input wire logic [3:0] table2_code,
   input wire logic [3:0] table3_code,
   input wire logic [3:0] table4_code,
   input wire logic [3:0] regulator_hot_code,
   input wire logic [3:0] processor_hot_code,
   input wire logic override_en,
   input wire logic [3:0] override_code,
   input wire logic spinup_active,
   input wire logic [3:0] applied_duty_code
);
   localparam int dur_tab [8] = '{0, 100, 250, 400, 700, 1000, 2000, 4000};
   logic [7:0] cfg_ff;
   logic [3:0] map_ff;
   logic [3:0] req;
   logic [3:0] dur;
   logic zero_ff;
   int run_ff;
   int dur_cyc;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_ff <= 8'h00;
         map_ff <= 4'h0;
      end else if (reg_wr_en && reg_addr == 8'hce) begin
         cfg_ff <= reg_wdata;
      end else if (reg_wr_en && reg_addr == 8'hcf) begin
         map_ff <= reg_wdata[3:0];
      end
   end
   // Previous request was zero, and length of the running spin-up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         zero_ff <= 1'b1;
         run_ff <= 0;
      end else begin
         zero_ff <= req == 4'h0;
         run_ff <= spinup_active ? run_ff + 1 : 0;
      end
   end
   always_comb begin
      req = table1_code;
      if (table2_code > req) req = table2_code;
      if (table3_code > req) req = table3_code;
      if (table4_code > req) req = table4_code;
      if (regulator_hot_code > req) req = regulator_hot_code;
      if (processor_hot_code > req) req = processor_hot_code;
      if (override_en && override_code > req) req = override_code;
   end
   assign dur = {cfg_ff[4], cfg_ff[7:5]};
   assign dur_cyc = clk_per_ms * (dur[3] ? 6000 + 2000 * int'(dur[2:0])
      : dur_tab[dur[2:0]]);
   // ****************
   // Properties
   // ****************
   sequence spin_trigger;
      req != 4'h0 && zero_ff && cfg_ff[3:0] != 4'h0 && dur != 4'h0
         && !spinup_active;
   endsequence
   sequence spin_end;
      $fell(spinup_active) && req != 4'h0 && cfg_ff[3:0] != 4'h0;
   endsequence
   spin_start_a: assert property (
      spin_trigger |=> spinup_active && applied_duty_code == cfg_ff[3:0])
      else $error("spin-up did not start");
   spin_cause_a: assert property (
      $rose(spinup_active) |-> $past(zero_ff) && $past(req) != 4'h0)
      else $error("spin-up without a rise from zero");
   no_spin_a: assert property (
      cfg_ff[3:0] == 4'h0 || dur == 4'h0 |=> !spinup_active)
      else $error("spin-up while disabled");
   spin_duty_a: assert property (
      spinup_active && $stable(cfg_ff) |-> applied_duty_code == cfg_ff[3:0])
      else $error("wrong spin-up duty code");
   spin_max_a: assert property (
      spinup_active |-> run_ff <= dur_cyc + 1)
      else $error("spin-up too long");
   spin_min_a: assert property (
      spin_end |-> run_ff >= dur_cyc - 1)
      else $error("spin-up too short");
   req_drive_a: assert property (
      !spinup_active |-> applied_duty_code == $past(req))
      else $error("applied code is not the largest request");
   cfg_read_a: assert property (
      reg_rd_en && reg_addr == 8'hce |=> reg_rdata == $past(cfg_ff))
      else $error("spin-up register read back wrong");
   freq_read_a: assert property (
      reg_rd_en && reg_addr == 8'hcf |=> reg_rdata == {4'h0, $past(map_ff)})
      else $error("frequency register read back wrong");
endmodule
bind fan_pwm_spinup fan_pwm_spinup_asserts #(
   .clk_hz(clk_hz), .clk_per_ms(clk_per_ms)
) i_fan_pwm_spinup_asserts (
   .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .table1_code(table1_code),
   .table2_code(table2_code), .table3_code(table3_code),
   .table4_code(table4_code), .regulator_hot_code(regulator_hot_code),
   .processor_hot_code(processor_hot_code), .override_en(override_en),
   .override_code(override_code), .spinup_active(spinup_active),
   .applied_duty_code(applied_duty_code)
);
`default_nettype wire

// *** fan_pwm_spinup_tb.sv ***
// Self-checking bench for the second fan output spin-up block
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_spinup_tb;
   localparam int clk_hz = 360000;
   localparam int clk_per_ms = 2;
   typedef struct {
      logic [2:0] f;
      logic m;
      int s;
      logic [3:0] c;
      int num;
      int den;
   } row_t;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr_en = 1'b0;
   logic reg_rd_en = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [3:0] src [6] = '{default: 4'h0};
   logic override_en = 1'b0;
   logic [3:0] override_code = 4'h0;
   logic [7:0] reg_rdata;
   logic second_fan_output;
   logic spinup_active;
   logic [3:0] applied_duty_code;
   logic [31:0] period_cycles;
   logic [31:0] high_cycles;
   logic [31:0] edge_cnt;
   int num_errors = 0;
   int checks_done = 0;
   int hz [8] = '{22500, 96, 84, 72, 60, 48, 36, 12};
   // Source 6 is the override, disabled unless it is the one tested; untested sources 0 to 5 are set to code 1
   row_t rows [12] = '{
      '{3'h0, 1'b0, 0, 4'h1, 4, 16}, '{3'h0, 1'b0, 1, 4'h7, 10, 16},
      '{3'h0, 1'b0, 2, 4'hc, 15, 16}, '{3'h0, 1'b1, 3, 4'h2, 8, 28},
      '{3'h0, 1'b1, 4, 4'hb, 20, 28}, '{3'h0, 1'b1, 5, 4'hc, 24, 28},
      '{3'h0, 1'b1, 6, 4'ha, 16, 28}, '{3'h0, 1'b0, 6, 4'h5, 8, 16},
      '{3'h1, 1'b0, 0, 4'h4, 10, 28}, '{3'h2, 1'b1, 3, 4'h9, 15, 28},
      '{3'h3, 1'b0, 1, 4'h6, 12, 28}, '{3'h4, 1'b1, 2, 4'h3, 9, 28}
   };
   always #5 clk = ~clk;
   fan_pwm_spinup #(.clk_hz(clk_hz), .clk_per_ms(clk_per_ms))
   i_fan_pwm_spinup (
      .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .table1_code(src[0]), .table2_code(src[1]),
      .table3_code(src[2]), .table4_code(src[3]),
      .regulator_hot_code(src[4]), .processor_hot_code(src[5]),
      .override_en(override_en), .override_code(override_code),
      .second_fan_output(second_fan_output), .spinup_active(spinup_active),
      .applied_duty_code(applied_duty_code)
   );
   fan_model i_fan_model (
      .clk(clk), .arst_n(arst_n), .pwm_in(second_fan_output),
      .period_cycles(period_cycles), .high_cycles(high_cycles),
      .edge_cnt(edge_cnt)
   );
   task automatic report_and_stop();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic flag(input string what);
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      checks_done++;
      if (got !== exp) flag(what);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge clk);
      reg_wr_en = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge clk);
      reg_rd_en = 1'b0;
      cmp({24'h0, reg_rdata}, {24'h0, exp}, "register read");
   endtask
   task automatic wait_per(input int n, input int lim);
      int e;
      int i;
      e = int'(edge_cnt);
      for (i = 0; i < lim && int'(edge_cnt) - e < n; i++) @(negedge clk);
      if (i == lim) begin
         flag("no drive pulses");
         report_and_stop();
      end
   endtask
   task automatic run_row(input row_t r);
      int p;
      p = clk_hz / hz[r.f];
      wr_reg(8'hcf, {4'h0, r.m, r.f});
      foreach (src[k]) src[k] = (k == r.s) ? r.c : 4'h1;
      override_en = (r.s == 6);
      override_code = (r.s == 6) ? r.c : 4'hf;
      wait_per(3, 40000);
      cmp(applied_duty_code, r.c, "duty code");
      cmp(period_cycles, p, "period");
      cmp(high_cycles, (p * r.num + r.den - 1) / r.den, "high time");
   endtask
   task automatic spin(input logic [7:0] cfg, input int exp);
      int i;
      time t0;
      wr_reg(8'hce, cfg);
      src[0] = 4'h5;
      @(negedge clk);
      t0 = $time;
      if (exp > 0) cmp(applied_duty_code, cfg[3:0], "spin duty");
      if (exp > 9000) begin
         wait_per(3, 8000);
         cmp(high_cycles, (clk_hz / 22500 * 9 + 27) / 28, "spin map");
      end
      for (i = 0; i < 40000 && spinup_active === 1'b1; i++) @(negedge clk);
      if (i == 40000) begin
         flag("spin-up never ended");
         report_and_stop();
      end
      i = int'(($time - t0) / 10);
      cmp(i >= exp - 1 && i <= exp + 1, 1, "spin length");
      cmp(applied_duty_code, 4'h5, "after spin");
      src[0] = 4'h0;
      repeat (3) @(negedge clk);
   endtask
   // ****************
   // Scenarios
   // ****************
   initial begin
      repeat (16) @(negedge clk);
      cmp({second_fan_output, spinup_active, applied_duty_code}, 0, "reset");
      arst_n = 1'b1;
      rd_reg(8'hce, 8'h00);
      rd_reg(8'hcf, 8'h00);
      wr_reg(8'hce, 8'ha5);
      wr_reg(8'hcf, 8'hfb);
      wr_reg(8'h10, 8'h55);
      rd_reg(8'hce, 8'ha5);
      rd_reg(8'hcf, 8'h0b);
      rd_reg(8'h10, 8'h00);
      wr_reg(8'hce, 8'h00);
      foreach (rows[i]) run_row(rows[i]);
      src = '{default: 4'h0};
      wr_reg(8'hcf, 8'h08);
      spin(8'h23, 100 * clk_per_ms);
      spin(8'h63, 400 * clk_per_ms);
      spin(8'h33, 8000 * clk_per_ms);
      spin(8'h20, 0);
      spin(8'h03, 0);
      wr_reg(8'hce, 8'h23);
      src[0] = 4'h5;
      repeat (20) @(negedge clk);
      arst_n = 1'b0;
      src[0] = 4'h0;
      @(negedge clk);
      cmp({spinup_active, applied_duty_code}, 0, "mid-run reset");
      arst_n = 1'b1;
      rd_reg(8'hce, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** fan_pwm_wave.sv ***
// Waveform generator: duty fraction and period to a pin level
`timescale 1ns/10ps
`default_nettype none
module fan_pwm_wave
   import fan_pwm_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [23:0] period_cycles,
   input wire logic [5:0] duty_num,
   input wire logic [5:0] duty_den,
   output logic pwm_out
);
   logic [23:0] cnt_ff;
   logic [23:0] period_ff;
   logic [5:0] num_ff;
   logic [5:0] den_ff;
   logic period_end;
   logic [31:0] lhs;
   logic [31:0] rhs;

   assign period_end = (cnt_ff >= period_ff - 24'h000001);

   // Period and duty are taken only at period end so pulses never tear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= 24'h000000;
         period_ff <= 24'h000001;
         num_ff <= 6'h00;
         den_ff <= 6'h01;
      end else if (period_end) begin
         cnt_ff <= 24'h000000;
         period_ff <= period_cycles;
         num_ff <= duty_num;
         den_ff <= duty_den;
      end else begin
         cnt_ff <= cnt_ff + 24'h000001;
      end
   end

   // High while cnt/period < num/den
   assign lhs = 32'(cnt_ff) * 32'(den_ff);
   assign rhs = 32'(period_ff) * 32'(num_ff);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= (lhs < rhs);
      end
   end
endmodule
`default_nettype wire
